// ===== src/dpc_pkg.sv
// package: constants, register map and types shared by the code converter
package dpc_pkg;

  // ----------------------------------------------------------------------
  // widths and rates
  // ----------------------------------------------------------------------
  localparam int LIN_W        = 14;                    // linear pcm codeword width
  localparam int CW_W         = 8;                     // compressed codeword width
  localparam int MCLK_KHZ     = 2048;                  // master/dsm clock rate, kHz
  localparam int BIT_KBPS     = 64;                    // fixed-mode pcm bit rate, kbit/s
  localparam int BIT_DIV      = MCLK_KHZ / BIT_KBPS;   // master edges per pcm bit
  localparam int RX_SAMPLE_AT = BIT_DIV / 2;           // mid-bit sample point
  localparam int CNT_W        = 8;                     // decimator counter width
  localparam int DIV_W        = $clog2(BIT_DIV);       // bit divider width

  // ----------------------------------------------------------------------
  // code values
  // ----------------------------------------------------------------------
  localparam logic [CW_W-1:0]  FLIP_MASK  = 8'h55;     // alternate bit flip pattern
  localparam int               PEAK_MAG   = 8192;      // peak linear magnitude
  localparam logic [LIN_W-1:0] MOD_OFFSET = 14'(PEAK_MAG / 16); // modulator offset
  localparam logic [CNT_W-1:0] CNT_LAST   = 8'hFF;     // last count of a sample period

  // ----------------------------------------------------------------------
  // apb register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam int              ADDR_W     = 12;
  localparam logic [11:0]     REG_CTRL   = 12'h000;    // control
  localparam logic [11:0]     REG_STATUS = 12'h004;    // live status
  localparam logic [11:0]     REG_ENC    = 12'h008;    // encode path words
  localparam logic [11:0]     REG_DEC    = 12'h00C;    // decode path words
  localparam int              CTRL_FLIP_BIT = 0;       // alternate bit flip enable
  localparam logic            CTRL_FLIP_RST = 1'b1;    // flip on after reset
  localparam int              WORD_LIN_LSB  = 16;      // linear field position in words
  localparam int              ST_MODE_BIT   = 0;
  localparam int              ST_DLY_LSB    = 1;
  localparam int              ST_SIGN_BIT   = 3;
  localparam int              ST_SQ_BIT     = 4;
  localparam int              ST_RXBUSY_BIT = 5;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic       enc_clk;   // encode 2,048 kHz clock
    logic       dec_clk;   // decode 2,048 kHz clock (burst mode)
    logic       dsm_in;    // delta sigma stream from modulator
    logic       pcm_rx;    // serial pcm in
    logic       fsync;     // sign-bit timing vector
    logic       tx_bclk;   // burst transmit bit clock
    logic       rx_bclk;   // burst receive bit clock
    logic       mode_sel;  // strap: 0 fixed 64k, 1 burst
    logic [1:0] dly_sel;   // strap: receive displacement in bits
    logic       tx_sig_in; // signalling bits into transmit shifter
  } dpc_pin_in_type;

  typedef enum logic {RX_IDLE, RX_SHIFT} dpc_rx_state_type;

endpackage : dpc_pkg

// ===== src/dpc_dsm_mod.sv
// all-digital delta sigma modulator for the decode path
`timescale 1ns/1ps
`default_nettype none

module dpc_dsm_mod #(
  parameter int K     = 15,   // modulator input width
  parameter int ACC_W = K + 2 // integrator width
) (
  input  wire logic                      pclk,    // system clock
  input  wire logic                      presetn, // async reset, active low
  input  wire logic                      step,    // one modulator cycle
  input  wire logic [dpc_pkg::LIN_W-1:0] lin_in,  // held linear sample
  output var  logic                      bit_out  // delta sigma output
);
  import dpc_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (K < LIN_W + 1 || ACC_W < K + 1) begin : g_bad
    $error("dpc_dsm_mod: K must exceed the linear width by one");
  end

  logic [ACC_W-1:0] acc_q;   // integrator
  logic [K-1:0]     x_w;     // offset input
  logic [K:0]       e_w;     // difference term
  logic [ACC_W-1:0] e_ext_w; // sign-extended difference

  // offset of a sixteenth of peak widens the input by one bit so it never wraps
  assign x_w = K'($signed(lin_in)) + K'(MOD_OFFSET);
  // no subtractor: low bits pass, the two top bits are the inverted signs
  assign e_w = {~acc_q[ACC_W-1], ~x_w[K-1], x_w[K-2:0]};
  assign e_ext_w = ACC_W'($signed(e_w));

  // ----------------------------------------------------------------------
  // integrator, stepped once per modulator clock
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
    end else if (step) begin
      acc_q <= acc_q + e_ext_w;
    end
  end

  // the output bit is the integrator sign, straight from its flip-flop
  assign bit_out = acc_q[ACC_W-1];

endmodule // dpc_dsm_mod

`default_nettype wire

// ===== src/dpc_top.sv
// delta sigma / a-law pcm code converter with apb control
//
// Overview of operation
// - encode 2,048k dsm bits, 64k pcm out
// - burst pcm output on external clocks
// - decode pcm into 2,048k dsm stream
// - triangular weighting of 256 bits per period
// - counter, weight logic, retime, accumulator, latch
// - sawtooth 0..127, top bit splits phases
// - top bit folds the ramp, input bit alone signs the term
// - square wave and sign fed back
// - one 14-bit codeword per sample period
// - linear sample held for modulator all period
// - segment first, then interval by selection
// - alternate bit flip, switchable for test
// - expander mirrors the compressor
// - strap pin selects interface mode
// - fixed mode bit clock from master
// - straps set receive delay zero to three in fixed mode
// - burst mode uses external bit clocks
// - burst mode exposes both shift registers
// - burst mode: separate encode, decode clocks
// - decoder holds full-width sample all period
// - modulator adds one-sixteenth peak offset
// - difference from low bits, inverted signs
// - latch clock sets cycle, sign out
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module dpc_top #(
  parameter int MOD_K = 15 // digital modulator width
) (
  input  wire logic                        pclk,       // 20 MHz system clock
  input  wire logic                        presetn,    // async reset, active low
  input  wire dpc_pkg::dpc_pin_in_type     pins,       // asynchronous device pins
  output var  logic                        dsm_out,    // decode delta sigma stream
  output var  logic                        sq_wave,    // 8 kHz square wave to modulator
  output var  logic                        sign_fb,    // codeword sign to modulator
  output var  logic                        pcm_tx,     // serial pcm out
  output var  logic                        rx_sig_out, // bits leaving receive shifter
  input  wire logic [dpc_pkg::ADDR_W-1:0]  paddr,      // apb address
  input  wire logic                        psel,       // apb select
  input  wire logic                        penable,    // apb enable
  input  wire logic                        pwrite,     // apb direction
  input  wire logic [31:0]                 pwdata,     // apb write data
  input  wire logic [3:0]                  pstrb,      // apb byte strobes
  output var  logic [31:0]                 prdata,     // apb read data
  output var  logic                        pready,     // apb ready
  output var  logic                        pslverr     // apb error
);
  import dpc_pkg::*;

  // ----------------------------------------------------------------------
  // elaboration check
  // ----------------------------------------------------------------------
  if (MOD_K < LIN_W + 1) begin : g_bad
    $error("dpc_top: MOD_K too small for the linear codeword");
  end

  // ----------------------------------------------------------------------
  // a-law helpers
  // ----------------------------------------------------------------------
  // linear to a-law: segment from leading one, then interval selected by it
  function automatic logic [CW_W-1:0] compress(input logic [LIN_W-1:0] lin);
    logic        neg;
    logic [11:0] mag;
    logic [2:0]  seg;
    logic [11:0] shifted;
    neg = lin[LIN_W-1];
    // ones complement keeps the most negative value from overflowing
    mag = neg ? ~lin[LIN_W-2:1] : lin[LIN_W-2:1];
    casez (mag[11:5])
      7'b1??????: seg = 3'd7;
      7'b01?????: seg = 3'd6;
      7'b001????: seg = 3'd5;
      7'b0001???: seg = 3'd4;
      7'b00001??: seg = 3'd3;
      7'b000001?: seg = 3'd2;
      7'b0000001: seg = 3'd1;
      default:    seg = 3'd0;
    endcase
    shifted = mag >> ((seg == 3'd0) ? 3'd1 : seg);
    return {~neg, seg, shifted[3:0]};
  endfunction

  // a-law to linear: the same selection run backwards
  function automatic logic [LIN_W-1:0] expand(input logic [CW_W-1:0] cw);
    logic        neg;
    logic [2:0]  seg;
    logic [11:0] mag;
    logic [11:0] base;
    neg  = ~cw[7];
    seg  = cw[6:4];
    base = {6'h00, 1'b1, cw[3:0], 1'b1};
    mag  = (seg == 3'd0) ? {7'h00, cw[3:0], 1'b1} : (base << (seg - 3'd1));
    return {neg, (neg ? ~mag : mag), 1'b0};
  endfunction

  // ----------------------------------------------------------------------
  // pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  dpc_pin_in_type sync1_q; // first stage, read only by sync2_q
  dpc_pin_in_type sync2_q; // safe copy of the pins
  dpc_pin_in_type prev_q;  // last safe copy, for edges

  // two flops per pin; the pins have no relation to pclk
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      prev_q  <= '0;
    end else begin
      sync1_q <= pins;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  wire logic       enc_rise_w = sync2_q.enc_clk & ~prev_q.enc_clk; // encode clock edge
  wire logic       dec_rise_w = sync2_q.dec_clk & ~prev_q.dec_clk; // decode clock edge
  wire logic       txb_rise_w = sync2_q.tx_bclk & ~prev_q.tx_bclk; // burst tx bit edge
  wire logic       rxb_rise_w = sync2_q.rx_bclk & ~prev_q.rx_bclk; // burst rx bit edge
  wire logic       burst_w    = sync2_q.mode_sel;
  wire logic [1:0] dly_w      = sync2_q.dly_sel;
  // burst mode runs decode from its own clock so the directions need not match
  wire logic       dec_step_w = burst_w ? dec_rise_w : enc_rise_w;

  // ----------------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------------
  logic flip_en_q; // alternate bit flip enable
  wire logic [CW_W-1:0] flip_w = flip_en_q ? FLIP_MASK : 8'h00;

  // ----------------------------------------------------------------------
  // decimator: counter, weight, retime, accumulator, latch
  // ----------------------------------------------------------------------
  logic [CNT_W-1:0] cnt_q;     // free-running up-counter
  logic             ds_bit_q;  // retimed dsm input bit
  logic [LIN_W-1:0] acc_q;     // 14-bit accumulator
  logic [LIN_W-1:0] lin_enc_q; // latched linear codeword

  // the fold turns two sawtooth ramps into one triangle over the full period
  wire logic [6:0]       fold_w = cnt_q[7] ? ~cnt_q[6:0] : cnt_q[6:0];
  // halving the weight keeps 256 full-scale terms inside 14 bits
  wire logic [LIN_W-1:0] wt_w   = {8'h00, fold_w[6:1]};
  wire logic [LIN_W-1:0] term_w = ds_bit_q ? wt_w : (~wt_w + 14'h0001);
  wire logic [LIN_W-1:0] sum_w  = acc_q + term_w;
  wire logic             last_w = (cnt_q == CNT_LAST);                  // end of period

  // one step per encode clock edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q     <= '0;
      ds_bit_q  <= 1'b0;
      acc_q     <= '0;
      lin_enc_q <= '0;
    end else if (enc_rise_w) begin
      cnt_q    <= cnt_q + 8'h01;
      ds_bit_q <= sync2_q.dsm_in;
      acc_q    <= last_w ? '0 : sum_w;
      if (last_w) begin
        lin_enc_q <= sum_w;
      end
    end
  end

  // feedback to the analogue modulator, registered
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_wave <= 1'b0;
      sign_fb <= 1'b0;
    end else begin
      sq_wave <= cnt_q[7];
      sign_fb <= lin_enc_q[LIN_W-1];
    end
  end

  // ----------------------------------------------------------------------
  // fixed-mode bit clock and timing vector history
  // ----------------------------------------------------------------------
  logic [DIV_W-1:0] div_q;  // master edges within a pcm bit
  logic [3:0]       hist_q; // timing vector, one entry per bit

  wire logic bit_tick_w = enc_rise_w & (div_q == '0);
  wire logic mid_tick_w = enc_rise_w & (div_q == DIV_W'(RX_SAMPLE_AT));

  // divide the master clock down to 64 kbit/s
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q  <= '0;
      hist_q <= '0;
    end else begin
      if (enc_rise_w) begin
        div_q <= div_q + 1'b1;
      end
      if (bit_tick_w) begin
        hist_q <= {hist_q[2:0], sync2_q.fsync};
      end
    end
  end

  // burst mode takes its bit clocks from outside, fixed mode from the divider
  wire logic tx_tick_w = burst_w ? txb_rise_w : bit_tick_w;
  wire logic rx_tick_w = burst_w ? rxb_rise_w : mid_tick_w;
  // the partner only marks the sign bit; the bit count places the rest
  wire logic rx_start_w = burst_w ? sync2_q.fsync : hist_q[dly_w];
  // signalling bits enter behind the codeword only in burst mode
  wire logic sig_in_w = burst_w & sync2_q.tx_sig_in;

  // ----------------------------------------------------------------------
  // transmit shifter
  // ----------------------------------------------------------------------
  logic [CW_W-1:0] tx_sh_q;   // transmit shift register
  logic [CW_W-1:0] tx_word_q; // last word sent, before flip

  wire logic [CW_W-1:0] enc_cw_w  = compress(lin_enc_q);
  wire logic [CW_W-1:0] tx_load_w = enc_cw_w ^ flip_w;

  // sign bit goes out at the marked bit, the rest follow msb first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_sh_q   <= '0;
      tx_word_q <= '0;
      pcm_tx    <= 1'b0;
    end else if (tx_tick_w) begin
      if (sync2_q.fsync) begin
        pcm_tx    <= tx_load_w[CW_W-1];
        tx_sh_q   <= {tx_load_w[CW_W-2:0], sig_in_w};
        tx_word_q <= enc_cw_w;
      end else begin
        pcm_tx  <= tx_sh_q[CW_W-1];
        tx_sh_q <= {tx_sh_q[CW_W-2:0], sig_in_w};
      end
    end
  end

  // ----------------------------------------------------------------------
  // receive shifter and expander
  // ----------------------------------------------------------------------
  dpc_rx_state_type rx_state_q; // idle or collecting a word
  logic [2:0]       rx_cnt_q;   // bits collected so far
  logic [CW_W-1:0]  rx_sh_q;    // receive shift register
  logic [CW_W-1:0]  rx_word_q;  // last word received, flip removed
  logic [LIN_W-1:0] lin_dec_q;  // held linear sample for the modulator

  wire logic [CW_W-1:0] rx_full_w = {rx_sh_q[CW_W-2:0], sync2_q.pcm_rx};
  wire logic [CW_W-1:0] rx_cw_w   = rx_full_w ^ flip_w;
  wire logic            rx_done_w = (rx_state_q == RX_SHIFT) && (rx_cnt_q == 3'd7);

  // the shifter always shifts so burst-mode signalling can be picked off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_sh_q    <= '0;
      rx_sig_out <= 1'b0;
    end else if (rx_tick_w) begin
      rx_sh_q    <= rx_full_w;
      rx_sig_out <= rx_sh_q[CW_W-1];
    end
  end

  // word framing: a start restarts the count even mid-word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= '0;
    end else if (rx_tick_w) begin
      if (rx_start_w) begin
        rx_state_q <= RX_SHIFT;
        rx_cnt_q   <= 3'd1;
      end else begin
        unique case (rx_state_q)
          RX_IDLE: begin
            rx_cnt_q <= '0;
          end
          RX_SHIFT: begin
            rx_cnt_q   <= rx_cnt_q + 3'd1;
            rx_state_q <= rx_done_w ? RX_IDLE : RX_SHIFT;
          end
        endcase
      end
    end
  end

  // a completed word replaces the held sample; it stands until the next
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_word_q <= '0;
      lin_dec_q <= '0;
    end else if (rx_tick_w && rx_done_w && !rx_start_w) begin
      rx_word_q <= rx_cw_w;
      lin_dec_q <= expand(rx_cw_w);
    end
  end

  // ----------------------------------------------------------------------
  // digital delta sigma modulator
  // ----------------------------------------------------------------------
  dpc_dsm_mod #(
    .K     (MOD_K),
    .ACC_W (MOD_K + 2)
  ) u_mod (
    .pclk    (pclk),
    .presetn (presetn),
    .step    (dec_step_w),
    .lin_in  (lin_dec_q),
    .bit_out (dsm_out)
  );

  // ----------------------------------------------------------------------
  // apb slave: one wait-free access, answer registered in setup
  // ----------------------------------------------------------------------
  wire logic setup_w  = psel & ~penable;
  wire logic commit_w = psel & penable & pready;
  wire logic hit_ctrl_w = (paddr == REG_CTRL);
  wire logic hit_w    = hit_ctrl_w | (paddr == REG_STATUS) |
                        (paddr == REG_ENC) | (paddr == REG_DEC);

  wire logic [31:0] rd_ctrl_w = {31'h0000_0000, flip_en_q};
  wire logic [31:0] rd_stat_w = {26'h000_0000, (rx_state_q == RX_SHIFT), sq_wave,
                                 sign_fb, dly_w, burst_w};
  wire logic [31:0] rd_enc_w  = {2'b00, lin_enc_q, 8'h00, tx_word_q};
  wire logic [31:0] rd_dec_w  = {2'b00, lin_dec_q, 8'h00, rx_word_q};
  wire logic [31:0] rd_mux_w  = hit_ctrl_w              ? rd_ctrl_w :
                                (paddr == REG_STATUS)   ? rd_stat_w :
                                (paddr == REG_ENC)      ? rd_enc_w  :
                                (paddr == REG_DEC)      ? rd_dec_w  : 32'h0000_0000;

  // answer is prepared in the setup cycle so pready comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup_w;
      pslverr <= setup_w & ~hit_w;
      if (setup_w) begin
        prdata <= pwrite ? 32'h0000_0000 : rd_mux_w;
      end
    end
  end

  // control write lands at the completing edge; byte lane 0 must be strobed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flip_en_q <= CTRL_FLIP_RST;
    end else if (commit_w && pwrite && hit_ctrl_w && pstrb[0]) begin
      flip_en_q <= pwdata[CTRL_FLIP_BIT];
    end
  end

endmodule // dpc_top

`default_nettype wire

// ===== tb/dpc_props.sv
// concurrent checks on the code converter's ports
`timescale 1ns/1ps
`default_nettype none

module dpc_props (
  input wire logic                       pclk,    // system clock
  input wire logic                       presetn, // async reset, active low
  input wire logic [dpc_pkg::ADDR_W-1:0] paddr,   // apb address
  input wire logic                       psel,    // apb select
  input wire logic                       penable, // apb enable
  input wire logic [31:0]                prdata,  // apb read data
  input wire logic                       pready,  // apb ready
  input wire logic                       pslverr, // apb error
  input wire logic                       sq_wave, // square wave feedback
  input wire logic                       sign_fb, // sign feedback
  input wire logic                       pcm_tx,  // serial pcm out
  input wire logic                       dsm_out  // decode stream
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ----------------------------------------------------------------------
  // register bus
  // ----------------------------------------------------------------------
  a_zero_wait: assert property (psel && !penable |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_unmapped: assert property (psel && !penable && paddr > 12'h00C |=> pslverr && prdata == 0)
    else $error("unmapped accepted");
  a_ok_mapped: assert property (psel && !penable && paddr <= 12'h00C && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("mapped refused");
  // ----------------------------------------------------------------------
  // link side: 400 ns link clock gives 8 pclk per link edge
  // ----------------------------------------------------------------------
  logic [10:0] sq_cnt_q;  // cycles since the square wave last moved
  logic        sq_prev_q; // square wave one cycle back
  logic        sq_seen_q; // one edge seen, so spans are whole half periods
  // a half period is too long for a delay range, so it is counted here
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sq_cnt_q  <= '0;
      sq_prev_q <= 1'b0;
      sq_seen_q <= 1'b0;
    end else begin
      sq_prev_q <= sq_wave;
      if (sq_wave != sq_prev_q) begin
        sq_cnt_q  <= '0;
        sq_seen_q <= 1'b1;
      end else if (sq_cnt_q != 11'h7FF) begin
        sq_cnt_q <= sq_cnt_q + 11'h001;
      end
    end
  end
  // an edge must land 1016 to 1032 cycles after the last, and not later
  wire logic sq_span_ok_w = (sq_wave != sq_prev_q) ? (sq_cnt_q >= 11'h3F7) : (sq_cnt_q < 11'h407);
  a_sq_half_period: assert property (sq_seen_q |-> sq_span_ok_w)
    else $error("square wave period");
  a_sign_latched: assert property ($changed(sign_fb) |=> $stable(sign_fb)[*8])
    else $error("sign moves twice");
  a_tx_bit_hold: assert property ($changed(pcm_tx) |=> $stable(pcm_tx)[*8])
    else $error("tx bit too short");
  a_dsm_step: assert property ($changed(dsm_out) |=> $stable(dsm_out)[*6])
    else $error("dsm steps too fast");
endmodule : dpc_props

bind dpc_top dpc_props u_props (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sq_wave(sq_wave),
  .sign_fb(sign_fb), .pcm_tx(pcm_tx), .dsm_out(dsm_out));
`default_nettype wire

// ===== tb/dpc_far_end.sv
// far-end highway model: link clock, timing vector, delayed loopback
`timescale 1ns/1ps
`default_nettype none

module dpc_far_end (
  input  wire logic       presetn, // restarts the frame count
  input  wire logic       pcm_tx,  // serial word from the codec
  input  wire logic [1:0] dly,     // receive displacement in bits
  output var  logic       enc_clk, // 2,500 kHz link clock, 400 ns period
  output var  logic       fsync,   // sign-bit timing vector
  output var  logic       pcm_rx,  // loopback into the codec
  output var  logic [7:0] tx_word  // last word caught
);
  logic [7:0]  cnt;  // link edge within a frame
  logic [7:0]  sh;   // bits caught mid-bit
  logic [95:0] hist; // one pcm_tx sample per link edge
  // well under the 6 MHz ceiling
  initial begin
    enc_clk = 1'b0;
    forever #200 enc_clk = ~enc_clk;
  end
  // vector straddles the codec's bit tick so sync lag cannot miss it
  assign fsync  = (cnt >= 8'h10) && (cnt < 8'h30);
  // delay is whole bits of 32 link edges
  assign pcm_rx = (dly == 2'h0) ? pcm_tx : hist[{dly, 5'h00} - 7'h01];
  // sample mid-bit, a word ends 256 edges after its sign
  always_ff @(posedge enc_clk or negedge presetn) begin
    if (!presetn) begin
      cnt     <= 8'h00;
      sh      <= 8'h00;
      hist    <= '0;
      tx_word <= 8'h00;
    end else begin
      cnt  <= cnt + 8'h01;
      hist <= {hist[94:0], pcm_tx};
      if (cnt[4:0] == 5'h10) sh <= {sh[6:0], pcm_tx};
      if (cnt == 8'h10) tx_word <= {sh[6:0], pcm_tx};
    end
  end
endmodule : dpc_far_end
`default_nettype wire

// ===== tb/tb.sv
// self-checking testbench for the code converter
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dpc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err; // bus and clocking
  logic        dsm_in, enc_clk, fsync, pcm_rx, dsm_out, sq_wave, sign_fb, pcm_tx;
  logic [1:0]  dly;       // receive displacement strap
  logic [11:0] paddr;     // apb address
  logic [3:0]  pstrb;     // apb strobes
  logic [31:0] pwdata, prdata, rd; // apb data
  logic [7:0]  tx_word;   // word caught by the far end
  int          failures, n_compared;
  int          n_ones;    // decode stream ones within a window
  dpc_pin_in_type pins;   // burst clocks and burst mode stay off
  assign pins = {enc_clk, 1'b0, dsm_in, pcm_rx, fsync, 1'b0, 1'b0, 1'b0, dly, 1'b0};

  dpc_top dut (.pclk(pclk), .presetn(presetn), .pins(pins), .dsm_out(dsm_out),
    .sq_wave(sq_wave), .sign_fb(sign_fb), .pcm_tx(pcm_tx), .rx_sig_out(), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  dpc_far_end far (.presetn(presetn), .pcm_tx(pcm_tx), .dly(dly), .enc_clk(enc_clk),
    .fsync(fsync), .pcm_rx(pcm_rx), .tx_word(tx_word));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    // wait as long as the slave needs; only the watchdog ends a hang
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wrap_up;
    $display("failures %0d n_compared %0d", failures, n_compared);
    if (failures == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // run takes about 16k cycles; hang guard well beyond
  initial begin
    #1_500_000;
    failures++;
    wrap_up();
  end
  // ----------------------------------------------------------------------
  // scenarios: all-ones stream with flip on, then all-zeros with flip off
  // ----------------------------------------------------------------------
  initial begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0;
    pwdata = '0; pstrb = '0; dsm_in = 1'b1; dly = 2'h0;
    repeat (5) @(posedge pclk);
    chk(32'({pcm_tx, sq_wave, pready}), 32'h0);
    presetn <= 1'b1;
    apb(1'b0, REG_CTRL, 32'h0, 4'h0); chk(rd, 32'(CTRL_FLIP_RST));
    apb(1'b0, 12'h010, 32'h0, 4'h0); chk({err, rd[30:0]}, 32'h8000_0000);
    apb(1'b1, REG_STATUS, 32'hFF, 4'hF);
    apb(1'b0, REG_STATUS, 32'h0, 4'h0); chk(32'(rd[2:0]), 32'h0);
    // let the loopback settle, then count decode stream ones over 512 steps
    repeat (4300) @(posedge pclk);
    n_ones = 0;
    repeat (4096) begin
      @(posedge pclk);
      if (dsm_out === 1'b1) n_ones++;
    end
    // held 0x1F80 plus the offset against a 2**14 level: ones near 976
    chk(32'(n_ones > 936 && n_ones < 1016), 32'h1);
    apb(1'b0, REG_ENC, 32'h0, 4'h0); chk(32'(rd[29:16]), 32'h1F80);
    chk(32'(rd[7:0]), 32'hFF);
    chk(32'(sign_fb), 32'h0);
    chk(32'(tx_word), 32'(8'hFF ^ FLIP_MASK));
    apb(1'b0, REG_DEC, 32'h0, 4'h0); chk(32'(rd[7:0]), 32'hFF);
    dsm_in <= 1'b0;
    dly <= 2'h3;
    apb(1'b1, REG_CTRL, 32'h0, 4'h0);
    apb(1'b0, REG_CTRL, 32'h0, 4'h0); chk(rd, 32'h1);
    apb(1'b1, REG_CTRL, 32'h0, 4'h1);
    apb(1'b0, REG_CTRL, 32'h0, 4'h0); chk(rd, 32'h0);
    // a clean period, its word sent, caught and looped back three bits late
    repeat (7200) @(posedge pclk);
    apb(1'b0, REG_ENC, 32'h0, 4'h0); chk(32'(rd[29:16]), 32'h2080);
    chk(32'(rd[7:0]), 32'h7F);
    chk(32'(tx_word), 32'h7F);
    apb(1'b0, REG_DEC, 32'h0, 4'h0); chk(32'(rd[7:0]), 32'h7F);
    apb(1'b0, REG_STATUS, 32'h0, 4'h0); chk(32'(rd[3:1]), 32'h7);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
